// >>> uei_defs.svh
// constants of the usb endpoint interrupt summary block
// Functional notes
// R01 - summary bit 7 is reserved, always reads 0; software never writes a one
// R02 - one summary flag per endpoint 0..6, fed only by its own sources
// R03 - flag sets as soon as any source of its endpoint is active; here it is registered and sets on the next sys_clk edge
// R04 - five sources: tx complete, out bank0, out bank1, setup, stall/crc
// R05 - sources come from each endpoint status register, no copy kept here
// R06 - usb interrupt for an endpoint needs its flag and enable bit both set
// R07 - flag clears only when all its sources clear; writes cannot clear it
// R08 - enable register: bits 0..6 per endpoint, bit 7 reads 0, resets 00h
// R09 - usb interrupt is or over endpoints of flag and enable
`ifndef UEI_DEFS_SVH
`define UEI_DEFS_SVH

// geometry
`define UEI_NUM_EP        7
`define UEI_NUM_SRC       5
`define UEI_RSVD_BIT      7

// register word addresses on the plain port
`define UEI_ADDR_SUMMARY  8'h00
`define UEI_ADDR_ENABLE   8'h01
`define UEI_ADDR_EVENT    8'h02
`define UEI_ADDR_EVMASK   8'h03
`define UEI_ADDR_SRCSEL   8'h04
`define UEI_ADDR_SRCVIEW  8'h05

// reset values
`define UEI_ENABLE_RST    7'h00
`define UEI_EVENT_RST     8'h00
`define UEI_EVMASK_RST    8'h00
`define UEI_SRCSEL_RST    3'h0
`define UEI_RDATA_RST     8'h00

// event register layout: bits 0..6 flag rose, bit 7 illegal write
`define UEI_EV_ILLEGAL    7

`endif

// >>> uei_pkg.sv
// types shared by the usb endpoint interrupt summary block
`default_nettype none
package uei_pkg;

  // interrupt sources of one endpoint, as its status register holds them
  typedef struct packed {
    logic stall_sent_or_crc_error;
    logic setup_received;
    logic out_received_bank1;
    logic out_received_bank0;
    logic transmit_complete;
  } uei_ep_src_type;

  // one request on the plain register port
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } uei_reg_req_type;

endpackage : uei_pkg
`default_nettype wire

// >>> uei_flag_cell.sv
// one endpoint summary flag with its rise pulse
`timescale 1ns/1ps
`default_nettype none
module uei_flag_cell (
  input  wire logic                    sys_clk,
  input  wire logic                    arst_n,
  input  wire uei_pkg::uei_ep_src_type src,
  output logic                         flag,
  output logic                         rise
);

  logic next_flag;

  // any of the five sources counts; the status register keeps them
  assign next_flag = |src; // R04 R05

  // follows the sources: set on any, clear only when all are gone
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      flag <= 1'b0;
    end else begin
      flag <= next_flag; // R03 R07
    end
  end

  // one-cycle pulse in the cycle the flag is seen to rise
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rise <= 1'b0;
    end else begin
      rise <= next_flag & ~flag;
    end
  end

endmodule // uei_flag_cell
`default_nettype wire

// >>> uei_event_regs.sv
// sticky event bits, their mask and the event interrupt
`timescale 1ns/1ps
`default_nettype none
`include "uei_defs.svh"
module uei_event_regs (
  input  wire logic       sys_clk,
  input  wire logic       arst_n,
  input  wire logic [7:0] evIn,
  input  wire logic       clrWr,
  input  wire logic       maskWr,
  input  wire logic [7:0] wdata,
  output logic      [7:0] evStatus,
  output logic      [7:0] evMask,
  output logic            evIrq
);

  logic [7:0] next_evStatus;

  // write one to clear; a new event in the same cycle wins over the clear
  assign next_evStatus = (evStatus & ~(clrWr ? wdata : 8'h00)) | evIn;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      evStatus <= `UEI_EVENT_RST;
    end else begin
      evStatus <= next_evStatus;
    end
  end

  // mask has the same layout as the status
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      evMask <= `UEI_EVMASK_RST;
    end else if (maskWr) begin
      evMask <= wdata;
    end
  end

  // level output while any unmasked sticky bit stands
  assign evIrq = |(evStatus & evMask);

endmodule // uei_event_regs
`default_nettype wire

// >>> uei_irq_summary.sv
// usb endpoint interrupt summary: flags, enables, register port, interrupts
//
// Decided for this implementation: the strobed register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "uei_defs.svh"
module uei_irq_summary (
  input  wire logic                           sys_clk,
  input  wire logic                           arst_n,
  input  wire uei_pkg::uei_ep_src_type [6:0]  epSrc,
  input  wire uei_pkg::uei_reg_req_type       regReq,
  output logic                         [7:0]  regRdata,
  output logic                         [6:0]  epIrqFlag,
  output logic                                usbIrq,
  output logic                                eventIrq
);

  // per-endpoint flag outputs of the cells
  logic [6:0] flagVec;
  logic [6:0] riseVec;

  // enable register, bit 7 not stored at all
  logic [6:0] irqEnable;

  // selector for the source read-back view
  logic [2:0] srcSel;

  // decoded register strikes
  logic       hitSummary;
  logic       hitEnable;
  logic       hitEvent;
  logic       hitEvMask;
  logic       hitSrcSel;
  logic       hitSrcView;
  logic       wrEnable;
  logic       wrEvent;
  logic       wrEvMask;
  logic       wrSrcSel;

  // illegal write detection
  logic       illegalWr;

  // sticky event side
  logic [7:0] evIn;
  logic [7:0] evStatus;
  logic [7:0] evMask;

  // read mux
  logic [7:0] next_regRdata;
  logic [7:0] summaryWord;
  logic [7:0] srcViewWord;

  // one flag cell per endpoint, each looks only at its own sources
  genvar ep;
  generate
    for (ep = 0; ep < `UEI_NUM_EP; ep = ep + 1) begin : g_ep
      uei_flag_cell u_cell (
        .sys_clk (sys_clk),
        .arst_n  (arst_n),
        .src     (epSrc[ep]), // R02
        .flag    (flagVec[ep]),
        .rise    (riseVec[ep])
      );
    end
  endgenerate

  // flags are visible to the rest of the usb module as levels
  assign epIrqFlag = flagVec;

  // address decode of the plain register port
  assign hitSummary = (regReq.addr == `UEI_ADDR_SUMMARY);
  assign hitEnable  = (regReq.addr == `UEI_ADDR_ENABLE);
  assign hitEvent   = (regReq.addr == `UEI_ADDR_EVENT);
  assign hitEvMask  = (regReq.addr == `UEI_ADDR_EVMASK);
  assign hitSrcSel  = (regReq.addr == `UEI_ADDR_SRCSEL);
  assign hitSrcView = (regReq.addr == `UEI_ADDR_SRCVIEW);

  // write strikes; summary and source view are read-only
  assign wrEnable = regReq.wr & hitEnable;
  assign wrEvent  = regReq.wr & hitEvent;
  assign wrEvMask = regReq.wr & hitEvMask;
  assign wrSrcSel = regReq.wr & hitSrcSel;

  // enable register: bits 0..6 only, reset all zero
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      irqEnable <= `UEI_ENABLE_RST; // R08
    end else if (wrEnable) begin
      irqEnable <= regReq.wdata[6:0]; // R08
    end
  end

  // selector for which endpoint the source view shows
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      srcSel <= `UEI_SRCSEL_RST;
    end else if (wrSrcSel) begin
      srcSel <= regReq.wdata[2:0];
    end
  end

  // a write to the summary, or a one into a reserved bit 7, is flagged
  // rather than silently dropped so firmware bugs show up early
  assign illegalWr = regReq.wr & (hitSummary
                   | (hitEnable & regReq.wdata[`UEI_RSVD_BIT])); // R01 R07

  // event inputs: each flag rising, plus the illegal write
  assign evIn = {illegalWr, riseVec};

  // sticky event bits with their mask and interrupt
  uei_event_regs u_events (
    .sys_clk  (sys_clk),
    .arst_n   (arst_n),
    .evIn     (evIn),
    .clrWr    (wrEvent),
    .maskWr   (wrEvMask),
    .wdata    (regReq.wdata),
    .evStatus (evStatus),
    .evMask   (evMask),
    .evIrq    (eventIrq)
  );

  // usb interrupt: any endpoint with both its flag and its enable set
  assign usbIrq = |(flagVec & irqEnable); // R06 R09

  // summary word: reserved bit 7 always zero
  assign summaryWord = {1'b0, flagVec}; // R01

  // source view reads the live status inputs, so no copy is held here;
  // a selector beyond endpoint 6 reads as zero
  always_comb begin
    srcViewWord = 8'h00;
    if (srcSel < 3'h7) begin
      srcViewWord = {3'h0, epSrc[srcSel]}; // R05
    end
  end

  // read mux; unmapped addresses answer zero
  always_comb begin
    next_regRdata = `UEI_RDATA_RST;
    if (regReq.rd) begin
      if (hitSummary) begin
        next_regRdata = summaryWord;
      end else if (hitEnable) begin
        next_regRdata = {1'b0, irqEnable}; // R08
      end else if (hitEvent) begin
        next_regRdata = evStatus;
      end else if (hitEvMask) begin
        next_regRdata = evMask;
      end else if (hitSrcSel) begin
        next_regRdata = {5'h00, srcSel};
      end else if (hitSrcView) begin
        next_regRdata = srcViewWord;
      end
    end
  end

  // read data stand only in the cycle after the read strobe
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      regRdata <= `UEI_RDATA_RST;
    end else begin
      regRdata <= next_regRdata;
    end
  end

endmodule // uei_irq_summary
`default_nettype wire

// >>> uei_irq_summary_asserts.sv
// checker: port assertions for the endpoint interrupt summary block
`timescale 1ns/1ps
`include "uei_defs.svh"
`default_nettype none
module uei_irq_summary_asserts (
  input wire logic                          sys_clk,
  input wire logic                          arst_n,
  input wire uei_pkg::uei_ep_src_type [6:0] epSrc,
  input wire uei_pkg::uei_reg_req_type      regReq,
  input wire logic                    [7:0] regRdata,
  input wire logic                    [6:0] epIrqFlag,
  input wire logic                          usbIrq,
  input wire logic                          eventIrq
);
  logic [6:0] anySrc;
  // any active source per endpoint, the cause a flag must follow
  always_comb begin
    for (int i = 0; i < 7; i++) begin
      anySrc[i] = |epSrc[i];
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  sequence sumRd;
    regReq.rd && regReq.addr == `UEI_ADDR_SUMMARY;
  endsequence
  sequence sumWr;
    regReq.wr && regReq.addr == `UEI_ADDR_SUMMARY;
  endsequence
  a_flag_follow:
    assert property (1'b1 |=> epIrqFlag == $past(anySrc))
    else $error("flag does not follow its sources");
  a_summary_read:
    assert property (sumRd |=> regRdata == {1'b0, $past(epIrqFlag)})
    else $error("summary read data wrong");
  a_rdata_idle:
    assert property (!regReq.rd |=> regRdata == 8'h00)
    else $error("read data outside read cycle");
  a_enable_rsvd:
    assert property (regReq.rd && regReq.addr == `UEI_ADDR_ENABLE
      |=> !regRdata[7]) else $error("enable bit 7 reads one");
  a_irq_gate:
    assert property (epIrqFlag == 7'h00 |-> !usbIrq)
    else $error("usb interrupt with no flag");
  a_irq_cause:
    assert property ($changed(usbIrq) |-> $changed(epIrqFlag)
      || $past(regReq.wr)) else $error("usb interrupt moved alone");
  a_no_swclear:
    assert property (sumWr ##0 anySrc == epIrqFlag
      |=> epIrqFlag == $past(epIrqFlag)) else $error("write moved flag");
  a_event_cause:
    assert property ($rose(eventIrq) |-> $past(regReq.wr)
      || $past(regReq.wr, 2) || $past(|epIrqFlag))
    else $error("event interrupt without cause");
endmodule // uei_irq_summary_asserts
`default_nettype wire

// >>> tb_top.sv
// testbench for the endpoint interrupt summary block
`timescale 1ns/1ps
`include "uei_defs.svh"
`default_nettype none
`define CHK(n, e, g) begin tests_run++; \
  if ((g) !== (e)) begin bad_count++; \
  $display("[FAIL] %s exp %h got %h", n, e, g); end end
module tb_top;
  logic                          sys_clk, arst_n, usbIrq, eventIrq;
  uei_pkg::uei_ep_src_type [6:0] epSrc;
  uei_pkg::uei_reg_req_type      regReq;
  logic                    [7:0] regRdata;
  logic                    [6:0] epIrqFlag;
  int                            bad_count = 0, tests_run = 0;
  uei_irq_summary uei_irq_summary_i (.sys_clk(sys_clk), .arst_n(arst_n),
    .epSrc(epSrc), .regReq(regReq), .regRdata(regRdata),
    .epIrqFlag(epIrqFlag), .usbIrq(usbIrq), .eventIrq(eventIrq));
  // 40 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    regReq.wr <= 1'b0;
    #1;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    regReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk);
    regReq.rd <= 1'b0;
    #1;
    `CHK("regRdata", e, regRdata)
  endtask
  // flag lags the source by one edge, so wait that edge out
  task automatic setSrc(input int i, input uei_pkg::uei_ep_src_type v);
    @(posedge sys_clk);
    epSrc[i] <= v;
    @(posedge sys_clk);
    #1;
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    epSrc = '0;
    regReq = '0;
    arst_n = 1'b0;
    repeat (3) @(posedge sys_clk);
    arst_n <= 1'b1;
    rd(`UEI_ADDR_SUMMARY, 8'h00);
    rd(`UEI_ADDR_ENABLE, 8'h00);
    rd(8'h07, 8'h00);
    for (int i = 0; i < 7; i++) begin
      for (int s = 0; s < 5; s++) begin
        setSrc(i, 5'h01 << s);
        `CHK("epIrqFlag", 7'h01 << i, epIrqFlag)
        rd(`UEI_ADDR_SUMMARY, 8'h01 << i);
        wr(`UEI_ADDR_SRCSEL, 8'(i));
        rd(`UEI_ADDR_SRCVIEW, 8'h01 << s);
        // ones into the summary must not clear anything
        wr(`UEI_ADDR_SUMMARY, 8'h7f);
        rd(`UEI_ADDR_SUMMARY, 8'h01 << i);
        `CHK("usbIrq", 1'b0, usbIrq)
        setSrc(i, 5'h00);
        rd(`UEI_ADDR_SUMMARY, 8'h00);
      end
    end
    wr(`UEI_ADDR_EVENT, 8'hff);
    rd(`UEI_ADDR_EVENT, 8'h00);
    wr(`UEI_ADDR_ENABLE, 8'hff);
    rd(`UEI_ADDR_ENABLE, 8'h7f);
    rd(`UEI_ADDR_EVENT, 8'h80);
    wr(`UEI_ADDR_EVENT, 8'h80);
    wr(`UEI_ADDR_ENABLE, 8'h04);
    setSrc(3, 5'h10);
    `CHK("usbIrq", 1'b0, usbIrq)
    setSrc(2, 5'h08);
    `CHK("usbIrq", 1'b1, usbIrq)
    wr(`UEI_ADDR_EVMASK, 8'h04);
    `CHK("eventIrq", 1'b1, eventIrq)
    rd(`UEI_ADDR_EVMASK, 8'h04);
    // selector beyond the last endpoint reads zero even with live sources
    wr(`UEI_ADDR_SRCSEL, 8'h07);
    rd(`UEI_ADDR_SRCSEL, 8'h07);
    rd(`UEI_ADDR_SRCVIEW, 8'h00);
    setSrc(2, 5'h00);
    setSrc(3, 5'h00);
    `CHK("usbIrq", 1'b0, usbIrq)
    `CHK("eventIrq", 1'b1, eventIrq)
    wr(`UEI_ADDR_EVENT, 8'h04);
    `CHK("eventIrq", 1'b0, eventIrq)
    rd(`UEI_ADDR_EVENT, 8'h08);
    // second reset in mid-run must drop the enables again
    @(posedge sys_clk);
    arst_n <= 1'b0;
    @(posedge sys_clk);
    arst_n <= 1'b1;
    rd(`UEI_ADDR_ENABLE, 8'h00);
    rd(`UEI_ADDR_EVENT, 8'h00);
    rd(`UEI_ADDR_EVMASK, 8'h00);
    rd(`UEI_ADDR_SRCSEL, 8'h00);
    `CHK("eventIrq", 1'b0, eventIrq)
    test_done();
  end
  // watchdog: the sequence needs well under 1000 cycles
  initial begin
    repeat (5000) @(posedge sys_clk);
    bad_count++;
    test_done();
  end
endmodule // tb_top
bind uei_irq_summary uei_irq_summary_asserts uei_irq_summary_asserts_i (
  .sys_clk(sys_clk), .arst_n(arst_n), .epSrc(epSrc), .regReq(regReq),
  .regRdata(regRdata), .epIrqFlag(epIrqFlag), .usbIrq(usbIrq),
  .eventIrq(eventIrq));
`default_nettype wire
